// File: hdl/pes_pkg.sv
package pes_pkg;
	localparam int          STS_W        = 16;
	localparam logic [15:0] STS_RESET    = 16'h0000;
	localparam int          BIT_TMR      = 0;
	localparam int          BIT_BM       = 4;
	localparam int          BIT_GBL      = 5;
	localparam int          BIT_PWR      = 8;
	localparam int          BIT_SLP      = 9;
	localparam int          BIT_RTC      = 10;
	localparam int          BIT_WAK      = 15;
	// bits that can ever hold a one; reserved and ignored bits excluded
	localparam logic [15:0] STS_DEFINED  = 16'h8731;
	localparam logic [1:0]  ADDR_ALIGN   = 2'h0;
	localparam int          OVERRIDE_MS  = 4000;
	localparam int          CLK_KHZ      = 25000;
	localparam int          OVERRIDE_CYC = OVERRIDE_MS * CLK_KHZ + 1;

	typedef enum logic [2:0] {
		PES_WORK  = 3'h1,
		PES_SLEEP = 3'h2,
		PES_OFF   = 3'h4
	} pes_pstate_t;

	// sleep depth; S4 gets special alarm handling
	typedef enum logic [1:0] {
		PES_S1S3 = 2'h0,
		PES_S4   = 2'h1
	} pes_depth_t;

	typedef struct packed {
		logic tmr;
		logic gbl;
		logic pwr;
		logic slp;
		logic rtc;
	} pes_en_t;

	typedef struct packed {
		logic [15:0] sts;
		logic        msb_q;
		logic [31:0] hold_cnt;
		logic        pwr_q;
		logic [15:0] rdata;
	} pes_state_t;
endpackage

// File: hdl/pes_status_bank.sv
module pes_status_bank #(
	parameter logic [15:0] IO_BASE      = 16'h0400,
	parameter logic [15:0] IMPL_MASK    = 16'h8731,
	parameter int          OVERRIDE_CNT = pes_pkg::OVERRIDE_CYC
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// system i/o access
	input  wire logic [15:0]        io_addr,
	input  wire logic               io_rd,
	input  wire logic               io_wr,
	input  wire logic [1:0]         io_be,
	input  wire logic [15:0]        io_wdata,
	output logic      [15:0]        io_rdata,
	// enables from the enable register
	input  wire pes_pkg::pes_en_t   enables,
	// power state and capability
	input  wire pes_pkg::pes_pstate_t pstate,
	input  wire pes_pkg::pes_depth_t  depth,
	input  wire logic               deep_sleep_alarm_capability,
	// event sources
	input  wire logic               counter_msb,
	input  wire logic               bus_request,
	input  wire logic               firmware_trigger,
	input  wire logic               power_button,
	input  wire logic               sleep_button,
	input  wire logic               alarm_request,
	// outputs
	output logic                    power_mgmt_interrupt,
	output logic                    wake_request,
	output logic                    force_soft_off
);
	import pes_pkg::*;

	pes_state_t s_reg;
	pes_state_t s_next;
	logic       sel;
	logic [15:0] wmask;
	logic [15:0] set_v;
	logic       asleep;
	logic       pwr_press;
	logic       wake_ev;
	logic       over;

	////////////////////////////////////////////////////////////////
	// decode: word-aligned base, byte or word lanes
	assign sel    = (io_addr[15:2] == IO_BASE[15:2]) && (io_addr[1:0] == ADDR_ALIGN);
	assign wmask  = {{8{io_be[1]}}, {8{io_be[0]}}};
	assign asleep = (pstate != PES_WORK);
	assign pwr_press = power_button && !s_reg.pwr_q;
	// power button always wakes, sleep button only when enabled
	assign wake_ev = asleep && (pwr_press
		|| (sleep_button && enables.slp)
		|| (alarm_request && enables.rtc));
	assign over = power_button && (s_reg.hold_cnt >= 32'(OVERRIDE_CNT));

	////////////////////////////////////////////////////////////////
	// next state; a set arriving with a clear wins
	always_comb begin
		s_next = s_reg;
		set_v = 16'h0000;
		set_v[BIT_TMR] = counter_msb ^ s_reg.msb_q;
		set_v[BIT_BM]  = bus_request;
		set_v[BIT_GBL] = firmware_trigger;
		set_v[BIT_PWR] = pwr_press;
		set_v[BIT_SLP] = sleep_button;
		// alarm from S4 flags only when capability declared
		set_v[BIT_RTC] = alarm_request && !(asleep && depth == PES_S4
			&& !deep_sleep_alarm_capability);
		set_v[BIT_WAK] = wake_ev;
		s_next.msb_q = counter_msb;
		s_next.pwr_q = power_button;
		s_next.hold_cnt = power_button ? ((s_reg.hold_cnt == 32'hFFFFFFFF)
			? s_reg.hold_cnt : s_reg.hold_cnt + 32'h1) : 32'h0;
		if (io_wr && sel) begin
			s_next.sts = s_reg.sts & ~(io_wdata & wmask);
		end
		s_next.sts = (s_next.sts | set_v) & IMPL_MASK & STS_DEFINED;
		if (over) begin
			s_next.sts[BIT_PWR] = 1'b0;
		end
		s_next.rdata = (io_rd && sel) ? (s_reg.sts & wmask) : 16'h0000;
		if (rst) begin
			s_next = '0;
			s_next.sts = STS_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////
	// outputs: enabled flags gate one level interrupt, power and sleep button flags only while working
	assign power_mgmt_interrupt = (s_reg.sts[BIT_TMR] && enables.tmr)
		|| (s_reg.sts[BIT_GBL] && enables.gbl)
		|| (!asleep && s_reg.sts[BIT_PWR] && enables.pwr)
		|| (!asleep && s_reg.sts[BIT_SLP] && enables.slp)
		|| (s_reg.sts[BIT_RTC] && enables.rtc);
	assign wake_request   = s_reg.sts[BIT_WAK] && asleep;
	assign force_soft_off = over;
	assign io_rdata       = s_reg.rdata;

	////////////////////////////////////////////////////////////////
	// checks
	property p_reserved_zero;
		@(posedge core_clk) disable iff (rst) (s_reg.sts & ~STS_DEFINED) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_tmr_toggle;
		@(posedge core_clk) disable iff (rst)
			(counter_msb != s_reg.msb_q) && IMPL_MASK[BIT_TMR] |=> s_reg.sts[BIT_TMR];
	endproperty
	a_tmr_toggle: assert property (p_tmr_toggle) else $error("timer flag missed");

	property p_bm_hold;
		@(posedge core_clk) disable iff (rst)
			s_reg.sts[BIT_BM] && !(io_wr && sel && io_wdata[BIT_BM] && io_be[0])
			|=> s_reg.sts[BIT_BM];
	endproperty
	a_bm_hold: assert property (p_bm_hold) else $error("bus master flag lost");

	property p_w1c;
		@(posedge core_clk) disable iff (rst)
			io_wr && sel && io_be[1] && io_wdata[BIT_RTC] && !alarm_request
			|=> !s_reg.sts[BIT_RTC];
	endproperty
	a_w1c: assert property (p_w1c) else $error("alarm flag not cleared");

	property p_other_block;
		@(posedge core_clk) disable iff (rst) (s_reg.sts & ~IMPL_MASK) == 16'h0000;
	endproperty
	a_other_block: assert property (p_other_block) else $error("foreign bit set");

	property p_irq_tmr;
		@(posedge core_clk) disable iff (rst)
			s_reg.sts[BIT_TMR] && enables.tmr |-> power_mgmt_interrupt;
	endproperty
	a_irq_tmr: assert property (p_irq_tmr) else $error("timer interrupt missing");

	property p_irq_gbl;
		@(posedge core_clk) disable iff (rst)
			firmware_trigger && enables.gbl && IMPL_MASK[BIT_GBL] |=> power_mgmt_interrupt;
	endproperty
	a_irq_gbl: assert property (p_irq_gbl) else $error("attention interrupt missing");

	property p_override;
		@(posedge core_clk) disable iff (rst) force_soft_off |=> !s_reg.sts[BIT_PWR];
	endproperty
	a_override: assert property (p_override) else $error("override left flag");

	property p_pwr_wake;
		@(posedge core_clk) disable iff (rst)
			asleep && pwr_press && (IMPL_MASK[BIT_WAK] && IMPL_MASK[BIT_PWR])
			|=> s_reg.sts[BIT_WAK] && s_reg.sts[BIT_PWR];
	endproperty
	a_pwr_wake: assert property (p_pwr_wake) else $error("power button wake lost");

	property p_slp_nowake;
		@(posedge core_clk) disable iff (rst)
			asleep && !s_reg.sts[BIT_WAK] && !enables.slp && !enables.rtc && !pwr_press
			&& !io_wr |=> !s_reg.sts[BIT_WAK];
	endproperty
	a_slp_nowake: assert property (p_slp_nowake) else $error("spurious wake");
endmodule

// File: tb/pes_status_bank_bench.sv
module pes_status_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pes_pkg::*;
	logic        core_clk = 0, rst = 1, io_rd = 0, io_wr = 0;
	logic [15:0] io_addr = 16'h0400, io_wdata = 16'h0000, io_rdata, r, d;
	logic [1:0]  io_be = 2'h3;
	pes_en_t     enables = '0;
	pes_pstate_t pstate = PES_WORK;
	pes_depth_t  depth = PES_S1S3;
	logic        cap = 0, msb = 0, bm = 0, fw = 0, pb = 0, sb = 0, al = 0;
	logic        irq, wake, soff;
	logic [31:0] seed = 32'h27F2;
	int          n_fail = 0, checks = 0;

	// free-running bench clock, 40 ns
	always #20 core_clk = ~core_clk;

	// short override count keeps the run small
	pes_status_bank #(.OVERRIDE_CNT(20)) u_pes_status_bank (.core_clk(core_clk), .rst(rst),
		.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_be(io_be), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .enables(enables), .pstate(pstate), .depth(depth),
		.deep_sleep_alarm_capability(cap), .counter_msb(msb), .bus_request(bm),
		.firmware_trigger(fw), .power_button(pb), .sleep_button(sb), .alarm_request(al),
		.power_mgmt_interrupt(irq), .wake_request(wake), .force_soft_off(soff));

	////////////////////////////////////////////////////////////////
	// inputs move 1 ns after the edge so sampling never races
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic cmp(logic [15:0] g, logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [1:0] b, logic [15:0] v);
		io_addr = a; io_be = b; io_wdata = v; io_wr = 1;
		tick();
		io_wr = 0;
	endtask
	// read data stands only in the cycle after the taken edge
	task automatic rd(logic [15:0] a);
		io_addr = a; io_be = 2'h3; io_rd = 1;
		tick();
		io_rd = 0;
		d = io_rdata;
	endtask
	// one cycle of every event source at once
	task automatic fire();
		msb = ~msb; bm = 1; fw = 1; pb = 1; sb = 1; al = 1;
		tick();
		bm = 0; fw = 0; pb = 0; sb = 0; al = 0;
	endtask
	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13; x ^= x >> 17; x ^= x << 5;
		return x;
	endfunction
	// working-state flags that survive a write-one-to-clear of w; bit 15 never expected
	function automatic logic [15:0] left(logic [15:0] w);
		return 16'h0731 & ~w;
	endfunction

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		tick(5);
		rst = 0;
		wr(16'h0400, 2'h3, 16'hFFFF);
		rd(16'h0400); cmp(d, 16'h0000);
		enables = '1;
		for (int i = 0; i < 4; i++) begin
			fire(); cmp({15'h0, irq}, 16'h0001);
			rd(16'h0400); cmp(d, 16'h0731);
			seed = xs(seed);
			r = seed[15:0];
			wr(16'h0400, 2'h3, r); rd(16'h0400); cmp(d, left(r));
			wr(16'h0400, 2'h3, 16'hFFFF); cmp({15'h0, irq}, 16'h0000);
		end
		$display("random clear test done");
		enables = '0; enables.tmr = 1; msb = ~msb;
		tick(); cmp({15'h0, irq}, 16'h0001);
		wr(16'h0400, 2'h3, 16'h0001); cmp({15'h0, irq}, 16'h0000);
		enables = '0; enables.gbl = 1; fw = 1;
		tick(); fw = 0; cmp({15'h0, irq}, 16'h0001);
		rd(16'h0400); cmp(d, 16'h0020);
		fire(); wr(16'h0400, 2'h1, 16'hFFFF); rd(16'h0400); cmp(d, 16'h0700);
		wr(16'h0404, 2'h3, 16'hFFFF); rd(16'h0400); cmp(d, 16'h0700);
		rd(16'h0404); cmp(d, 16'h0000);
		wr(16'h0400, 2'h2, 16'hFFFF); rd(16'h0400); cmp(d, 16'h0000);
		$display("interrupt and lane test done");
		pstate = PES_SLEEP; enables = '0; sb = 1;
		tick(); sb = 0; tick(); cmp({15'h0, wake}, 16'h0000);
		pb = 1; tick(); pb = 0; tick(2); cmp({15'h0, wake}, 16'h0001);
		rd(16'h0400); cmp(d, 16'h8300);
		depth = PES_S4; al = 1; tick(); al = 0; rd(16'h0400); cmp(d, 16'h8300);
		cap = 1; al = 1; tick(); al = 0; rd(16'h0400); cmp(d, 16'h8700);
		wr(16'h0400, 2'h3, 16'hFFFF); pstate = PES_WORK;
		$display("sleep test done");
		pb = 1;
		for (int k = 0; k < 40 && soff !== 1'b1; k++) tick();
		if (soff !== 1'b1) begin
			n_fail++;
			conclude();
		end
		// flag drops one edge after the override shows
		tick();
		rd(16'h0400); cmp(d, 16'h0000);
		pb = 0; tick();
		$display("override test done");
		conclude();
	end
endmodule
